// [core/dacif_pkg.sv]
// dacif_pkg: shared constants of the converter input controller
package dacif_pkg;

  // ==========================================================
  // word and frame widths
  localparam int unsigned WORD_W  = 14;
  localparam int unsigned FRAME_W = 16;

  // ==========================================================
  // timing, printed figures and derived cycle counts
  localparam int unsigned CLK_MHZ    = 10;
  localparam int unsigned T_DSU_NS   = 21;
  localparam int unsigned T_WR_NS    = 45;
  localparam int unsigned T_DH_NS    = 10;
  localparam int unsigned T_OUTPUT_LATCH_LOAD_NS  = 40;
  localparam int unsigned T_SYNC_NS  = 50;
  localparam int unsigned T_SHOLD_NS = 75;
  localparam int unsigned T_SCLK_NS  = 150;
  // least times round up to whole cycles
  localparam int unsigned DSU_CYC   = (T_DSU_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned WR_CYC    = (T_WR_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned DH_CYC    = (T_DH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned OUTPUT_LATCH_LOAD_CYC  = (T_OUTPUT_LATCH_LOAD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SYNC_CYC  = (T_SYNC_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SHOLD_CYC = (T_SHOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCLK_HALF =
    ((T_SCLK_NS * CLK_MHZ + 999) / 1000 + 1) / 2;

  // ==========================================================
  // register offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_LOAD = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;

  // ==========================================================
  // control fields
  localparam int unsigned CTRL_W      = 4;
  localparam int unsigned CTRL_SERIAL = 0;
  localparam int unsigned CTRL_MSB    = 1;
  localparam int unsigned CTRL_JUST   = 2;
  localparam int unsigned CTRL_AUTO   = 3;
  localparam logic [3:0]  CTRL_RST    = 4'h2;

  // ==========================================================
  // status fields
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_OVR   = 1;
  localparam int unsigned STAT_LPEND = 2;

endpackage

// [core/dacif_eng_if.sv]
// dacif_eng_if: request and pin bundle between controller and engines
interface dacif_eng_if;
  logic                       start;
  logic [dacif_pkg::WORD_W-1:0] word;
  logic                       msb_first;
  logic                       word_alignment_select;
  logic                       busy;
  logic                       sel_n;
  logic                       strobe_n;
  logic                       sclk;
  logic                       serial_bit_in;

  modport ctl (output start, word, msb_first, word_alignment_select,
               input  busy, sel_n, strobe_n, sclk, serial_bit_in);
  modport eng (input  start, word, msb_first, word_alignment_select,
               output busy, sel_n, strobe_n, sclk, serial_bit_in);
endinterface

// [core/dacif_par_wr.sv]
// dacif_par_wr: parallel write cycle with select and write strobe
module dacif_par_wr (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // engine bundle
  dacif_eng_if.eng eng
);
  typedef enum logic [1:0] {P_IDLE, P_SETUP, P_PULSE, P_HOLD} dacif_pst_t;

  dacif_pst_t st_q;
  logic [2:0] cnt_q;

  assign eng.busy  = (st_q != P_IDLE);
  assign eng.sclk  = 1'b0;
  assign eng.serial_bit_in = 1'b0;

  // ==========================================================
  // select low around a write strobe pulse
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q         <= P_IDLE;
      cnt_q        <= 3'h0;
      eng.sel_n    <= 1'b1;
      eng.strobe_n <= 1'b1;
    end else if (i_ce) begin
      unique case (st_q)
        P_IDLE: begin
          if (eng.start) begin
            eng.sel_n <= 1'b0;
            cnt_q     <= 3'(dacif_pkg::DSU_CYC - 1);
            st_q      <= P_SETUP;
          end
        end
        P_SETUP: begin
          if (cnt_q == 3'h0) begin
            eng.strobe_n <= 1'b0;
            cnt_q        <= 3'(dacif_pkg::WR_CYC - 1);
            st_q         <= P_PULSE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        P_PULSE: begin
          if (cnt_q == 3'h0) begin
            eng.strobe_n <= 1'b1;
            cnt_q        <= 3'(dacif_pkg::DH_CYC - 1);
            st_q         <= P_HOLD;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        P_HOLD: begin
          if (cnt_q == 3'h0) begin
            eng.sel_n <= 1'b1;
            st_q      <= P_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst || !i_ce);

  strobe_in_sel_a: assert property (
    !eng.strobe_n |-> !eng.sel_n)
    else $error("write strobe low without select");
  strobe_close_a: assert property (
    $fell(eng.strobe_n) |=> eng.strobe_n && !eng.sel_n ##1 eng.sel_n)
    else $error("write strobe pulse or select hold wrong");

endmodule // dacif_par_wr

// [core/dacif_ser_tx.sv]
// dacif_ser_tx: serial frame with marker, shift clock and data bit
module dacif_ser_tx #(
  parameter int unsigned HALF = dacif_pkg::SCLK_HALF
) (
  // clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire logic i_ce,
  // engine bundle
  dacif_eng_if.eng eng
);
  localparam int unsigned W   = dacif_pkg::WORD_W;
  localparam int unsigned F   = dacif_pkg::FRAME_W;
  localparam int unsigned PAD = F - W;

  typedef enum logic [2:0] {S_IDLE, S_SYNC, S_LOW, S_HIGH, S_TAIL}
    dacif_sst_t;

  dacif_sst_t   st_q;
  logic [2:0]   cnt_q;
  logic [3:0]   bits_q;
  logic [F-1:0] frame_q;
  logic [W-1:0] rev;
  logic [W-1:0] ordered;
  logic [F-1:0] frame_d;

  // ==========================================================
  // frame building: order, then word_alignment_select
  for (genvar g = 0; g < W; g++) begin : g_rev
    assign rev[g] = eng.word[W-1-g];
  end
  assign ordered = eng.msb_first ? eng.word : rev;
  assign frame_d = eng.word_alignment_select ? {{PAD{1'b0}}, ordered}
                               : {ordered, {PAD{1'b0}}};
  assign eng.busy  = (st_q != S_IDLE);
  assign eng.sel_n = 1'b1;

  // ==========================================================
  // marker low, sixteen symmetric clocks, then marker high
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_q         <= S_IDLE;
      cnt_q        <= 3'h0;
      bits_q       <= 4'h0;
      frame_q      <= '0;
      eng.strobe_n <= 1'b1;
      eng.sclk     <= 1'b1;
      eng.serial_bit_in    <= 1'b0;
    end else if (i_ce) begin
      unique case (st_q)
        S_IDLE: begin
          if (eng.start) begin
            eng.strobe_n <= 1'b0;
            frame_q      <= frame_d;
            eng.serial_bit_in    <= frame_d[F-1];
            bits_q       <= 4'(F - 1);
            cnt_q        <= 3'(dacif_pkg::SYNC_CYC - 1);
            st_q         <= S_SYNC;
          end
        end
        S_SYNC, S_HIGH: begin
          if (cnt_q == 3'h0) begin
            eng.sclk <= 1'b0;
            cnt_q    <= 3'(HALF - 1);
            st_q     <= S_LOW;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        S_LOW: begin
          if (cnt_q == 3'h0) begin
            eng.sclk <= 1'b1;
            if (bits_q == 4'h0) begin
              cnt_q <= 3'(dacif_pkg::SHOLD_CYC - 1);
              st_q  <= S_TAIL;
            end else begin
              frame_q   <= frame_q << 1;
              eng.serial_bit_in <= frame_q[F-2];
              bits_q    <= bits_q - 4'h1;
              cnt_q     <= 3'(HALF - 1);
              st_q      <= S_HIGH;
            end
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
        S_TAIL: begin
          if (cnt_q == 3'h0) begin
            eng.strobe_n <= 1'b1;
            st_q         <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 3'h1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  logic [4:0] falls_q;
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      falls_q <= 5'h0;
    end else if (i_ce) begin
      if (eng.strobe_n) begin
        falls_q <= 5'h0;
      end else if (st_q != S_LOW && cnt_q == 3'h0 && st_q != S_TAIL) begin
        falls_q <= falls_q + 5'h1;
      end
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst || !i_ce);

  fall_in_frame_a: assert property (
    $fell(eng.sclk) |-> !eng.strobe_n && $stable(eng.serial_bit_in))
    else $error("shift clock fell outside frame or data moved");
  frame_len_a: assert property (
    $rose(eng.strobe_n) |-> falls_q == 5'd16)
    else $error("frame did not carry sixteen clocks");
  first_bit_a: assert property (
    eng.start && !eng.busy && eng.msb_first && !eng.word_alignment_select
      |=> eng.serial_bit_in == $past(eng.word[W-1]))
    else $error("first bit is not the top bit");
  pad_first_a: assert property (
    eng.start && !eng.busy && eng.word_alignment_select |=> !eng.serial_bit_in)
    else $error("justified frame does not start with pad");

endmodule // dacif_ser_tx

// [core/dacif_top.sv]
// dacif_top: host controller driving the converter input pins
//
// Design decisions made here: the address map and the AHB-Lite slave port.
module dacif_top (
  // clock, reset, enable
  input  wire logic        i_mclk,
  input  wire logic        i_nrst,
  input  wire logic        i_ce,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  // converter pins
  output logic             o_cs_n,
  output logic             o_wr_sync_n,
  output logic [13:0]      o_data,
  output logic             o_output_latch_load_n,
  output logic             o_serial_mode
);
  localparam int unsigned W  = dacif_pkg::WORD_W;
  localparam int unsigned CW = dacif_pkg::CTRL_W;

  dacif_eng_if par_if ();
  dacif_eng_if ser_if ();

  logic          ap_v_q;
  logic          ap_wr_q;
  logic [7:0]    ap_addr_q;
  logic [CW-1:0] ctrl_q;
  logic [W-1:0]  word_q;
  logic          start_q;
  logic          ovr_q;
  logic          pend_q;
  logic          output_latch_load_act_q;
  logic [2:0]    output_latch_load_cnt_q;
  logic          eng_b_q;
  logic          accept;
  logic          wr_ev;
  logic          eng_busy;
  logic          busy;
  logic          serial;
  logic          wr_ctrl;
  logic          wr_data;
  logic          wr_load;
  logic          wr_stat;
  logic          fire;
  logic          done;
  logic [31:0]   rd_d;

  // ==========================================================
  // bus decode
  assign accept  = i_hsel && i_htrans[1] && i_hready;
  assign wr_ev   = ap_v_q && ap_wr_q;
  assign wr_ctrl = wr_ev && (ap_addr_q == dacif_pkg::OFF_CTRL);
  assign wr_data = wr_ev && (ap_addr_q == dacif_pkg::OFF_DATA);
  assign wr_load = wr_ev && (ap_addr_q == dacif_pkg::OFF_LOAD);
  assign wr_stat = wr_ev && (ap_addr_q == dacif_pkg::OFF_STAT);

  assign eng_busy = par_if.busy || ser_if.busy;
  assign busy     = start_q || eng_busy || output_latch_load_act_q;
  assign serial   = ctrl_q[dacif_pkg::CTRL_SERIAL];
  assign done     = eng_b_q && !eng_busy;
  assign fire     = pend_q && !busy;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ap_v_q    <= 1'b0;
      ap_wr_q   <= 1'b0;
      ap_addr_q <= 8'h00;
    end else if (i_ce) begin
      ap_v_q <= accept;
      if (accept) begin
        ap_wr_q   <= i_hwrite;
        ap_addr_q <= i_haddr[7:0];
      end
    end
  end

  // ==========================================================
  // read data, registered during the address phase
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (i_haddr[7:0])
      dacif_pkg::OFF_CTRL: rd_d[CW-1:0] = ctrl_q;
      dacif_pkg::OFF_DATA: rd_d[W-1:0]  = word_q;
      dacif_pkg::OFF_STAT: begin
        rd_d[dacif_pkg::STAT_BUSY]  = busy;
        rd_d[dacif_pkg::STAT_OVR]   = ovr_q;
        rd_d[dacif_pkg::STAT_LPEND] = pend_q;
      end
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hrdata    <= 32'h0000_0000;
      o_hreadyout <= 1'b0;
      o_hresp     <= 1'b0;
    end else if (i_ce) begin
      o_hreadyout <= 1'b1;
      o_hresp     <= 1'b0;
      if (accept && !i_hwrite) begin
        o_hrdata <= rd_d;
      end
    end
  end

  // ==========================================================
  // control, word and error flag
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q  <= dacif_pkg::CTRL_RST;
      word_q  <= '0;
      start_q <= 1'b0;
    end else if (i_ce) begin
      start_q <= 1'b0;
      if (wr_ctrl && !busy) begin
        ctrl_q <= i_hwdata[CW-1:0];
      end
      if (wr_data && !busy) begin
        word_q  <= i_hwdata[W-1:0];
        start_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      ovr_q <= 1'b0;
    end else if (i_ce) begin
      if ((wr_ctrl || wr_data) && busy) begin
        ovr_q <= 1'b1;
      end else if (wr_stat && i_hwdata[dacif_pkg::STAT_OVR]) begin
        ovr_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // engines
  assign par_if.start     = start_q && !serial;
  assign par_if.word      = word_q;
  assign par_if.msb_first = ctrl_q[dacif_pkg::CTRL_MSB];
  assign par_if.word_alignment_select   = ctrl_q[dacif_pkg::CTRL_JUST];
  assign ser_if.start     = start_q && serial;
  assign ser_if.word      = word_q;
  assign ser_if.msb_first = ctrl_q[dacif_pkg::CTRL_MSB];
  assign ser_if.word_alignment_select   = ctrl_q[dacif_pkg::CTRL_JUST];

  dacif_par_wr u_par (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .eng    (par_if.eng)
  );

  dacif_ser_tx #(
    .HALF (dacif_pkg::SCLK_HALF)
  ) u_ser (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_ce   (i_ce),
    .eng    (ser_if.eng)
  );

  // ==========================================================
  // output latch load: waits until no input transfer is open
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pend_q     <= 1'b0;
      output_latch_load_act_q <= 1'b0;
      output_latch_load_cnt_q <= 3'h0;
      eng_b_q    <= 1'b0;
    end else if (i_ce) begin
      eng_b_q <= eng_busy;
      // a new request in the firing cycle is kept
      pend_q  <= wr_load || (done && ctrl_q[dacif_pkg::CTRL_AUTO])
                 || (pend_q && !fire);
      if (fire) begin
        output_latch_load_act_q <= 1'b1;
        output_latch_load_cnt_q <= 3'(dacif_pkg::OUTPUT_LATCH_LOAD_CYC - 1);
      end else if (output_latch_load_act_q) begin
        if (output_latch_load_cnt_q == 3'h0) begin
          output_latch_load_act_q <= 1'b0;
        end else begin
          output_latch_load_cnt_q <= output_latch_load_cnt_q - 3'h1;
        end
      end
    end
  end

  // ==========================================================
  // pin registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cs_n                <= 1'b1;
      o_wr_sync_n           <= 1'b1;
      o_data                <= 14'h0000;
      o_output_latch_load_n <= 1'b1;
      o_serial_mode         <= 1'b0;
    end else if (i_ce) begin
      o_serial_mode         <= serial;
      o_output_latch_load_n <= !output_latch_load_act_q;
      if (serial) begin
        o_cs_n      <= 1'b1;
        o_wr_sync_n <= ser_if.strobe_n;
        o_data      <= {ser_if.serial_bit_in, ser_if.sclk,
                        ctrl_q[dacif_pkg::CTRL_MSB],
                        ctrl_q[dacif_pkg::CTRL_JUST], 10'h000};
      end else begin
        o_cs_n      <= par_if.sel_n;
        o_wr_sync_n <= par_if.strobe_n;
        o_data      <= word_q;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst || !i_ce);

  latch_excl_a: assert property (
    !o_output_latch_load_n |-> o_cs_n && o_wr_sync_n)
    else $error("load pulse while input transfer open");
  load_cause_a: assert property (
    $fell(o_output_latch_load_n) |-> $past(pend_q, 2)
      ##1 o_output_latch_load_n)
    else $error("load pulse without request or wrong width");
  par_word_a: assert property (
    !o_serial_mode && !o_wr_sync_n |-> o_data == word_q)
    else $error("parallel pins do not carry the word");
  start_route_a: assert property (
    start_q && !serial |=> par_if.busy ##[1:6] !o_cs_n)
    else $error("parallel start did not reach select");
  ser_start_a: assert property (
    start_q && serial |=> ser_if.busy ##1 !o_wr_sync_n)
    else $error("serial start did not lower frame marker");

  par_write_c: cover property (!o_serial_mode && $rose(o_wr_sync_n));
  ser_frame_c: cover property (o_serial_mode && $rose(o_wr_sync_n));
  load_c:      cover property ($fell(o_output_latch_load_n));
  ovr_c:       cover property ($rose(ovr_q));

endmodule // dacif_top

// [testbench/dacif_dev_model.sv]
// dacif_dev_model: behavioural converter input and output latches
module dacif_dev_model (
  // converter pins
  input  wire logic        i_cs_n,
  input  wire logic        i_wr_sync_n,
  input  wire logic [13:0] i_data,
  input  wire logic        i_load_n,
  input  wire logic        i_serial_mode,
  // observed state
  output logic [13:0]      o_out_latch,
  output logic [4:0]       o_bits,
  output logic             o_fault
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] in_latch;
  logic [15:0] frame;
  logic [13:0] ordered;
  logic [1:0]  fmt;
  realtime     t_r;
  realtime     t_f;
  realtime     hi;
  initial begin
    in_latch = '0;
    o_out_latch = '0;
    frame = '0;
    fmt = '0;
    o_bits = '0;
    o_fault = 1'b0;
    t_r = 0;
    t_f = 0;
    hi = 0;
  end
  // ==========================================================
  // input latch: parallel capture or end of serial frame
  always @(posedge i_cs_n) begin
    if (!i_serial_mode && !i_wr_sync_n) in_latch = i_data;
  end
  always @(negedge i_cs_n) begin
    if (i_serial_mode) o_fault = 1'b1;
  end
  always @(negedge i_wr_sync_n) begin
    if (i_serial_mode) o_bits = '0;
  end
  always @(negedge i_data[12]) begin
    if (i_serial_mode && !i_wr_sync_n) begin
      frame = {frame[14:0], i_data[13]};
      fmt = i_data[11:10];
      o_bits = o_bits + 5'd1;
      hi = $realtime - t_r;
      t_f = $realtime;
    end
  end
  // shift clock mark/space must stay within 40/60 and 60/40
  always @(posedge i_data[12]) begin
    t_r = $realtime;
    if (i_serial_mode && !i_wr_sync_n && o_bits > 5'd1) begin
      if (2 * hi > 3 * (t_r - t_f) || 3 * hi < 2 * (t_r - t_f))
        o_fault = 1'b1;
    end
  end
  always @(posedge i_wr_sync_n) begin
    if (i_serial_mode) begin
      ordered = fmt[0] ? frame[13:0] : frame[15:2];
      for (int i = 0; i < 14; i++)
        in_latch[i] = fmt[1] ? ordered[i] : ordered[13-i];
      if (o_bits != 5'd16) o_fault = 1'b1;
    end else if (!i_cs_n) begin
      in_latch = i_data;
    end
  end
  // ==========================================================
  // output latch, never while the input latch is open
  always @(negedge i_load_n) begin
    if (!i_serial_mode && !i_cs_n && !i_wr_sync_n) o_fault = 1'b1;
    else o_out_latch = in_latch;
  end
endmodule // dacif_dev_model

// [testbench/dacif_top_tb.sv]
// dacif_top_tb: self-checking bench of the converter input controller
module dacif_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        cs_n;
  logic        wr_n;
  logic [13:0] data;
  logic        load_n;
  logic        ser;
  logic [13:0] out_l;
  logic [4:0]  bits;
  logic        fault;
  logic [31:0] rd;
  logic [13:0] w;
  logic [13:0] exp_q[$];
  int          failures;
  int          tests_run;
  int unsigned seed_v;
  dacif_top u_dut (
    .i_mclk(clk), .i_nrst(nrst), .i_ce(ce), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
    .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata),
    .o_cs_n(cs_n), .o_wr_sync_n(wr_n), .o_data(data),
    .o_output_latch_load_n(load_n), .o_serial_mode(ser)
  );
  dacif_dev_model u_dev (
    .i_cs_n(cs_n), .i_wr_sync_n(wr_n), .i_data(data),
    .i_load_n(load_n), .i_serial_mode(ser),
    .o_out_latch(out_l), .o_bits(bits), .o_fault(fault)
  );
  always #50 clk = ~clk;
  // ==========================================================
  // comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    if (failures == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // single ahb-lite transfer, waits on hready with a bound
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 200);
    r = hrdata;
    if (n >= 200) begin
      failures++;
      conclude();
    end
  endtask
  task automatic idle_wait;
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      bus(1'b0, 8'h0c, 32'h0, s);
      n++;
    end while ((s[0] !== 1'b0 || s[2] !== 1'b0) && n < 100);
    if (n >= 100) begin
      failures++;
      conclude();
    end
  endtask
  // one word through the input latch to the output latch
  task automatic xfer(input logic [3:0] ctrl, input logic [13:0] wd);
    logic [31:0] r;
    bus(1'b1, 8'h00, {28'h0, ctrl}, r);
    exp_q.push_back(wd);
    bus(1'b1, 8'h04, {18'h0, wd}, r);
    if (!ctrl[3]) bus(1'b1, 8'h08, 32'h0, r);
    idle_wait();
  endtask
  // ==========================================================
  // output watcher: each load pulse settles one noted word
  always @(negedge load_n) begin
    if (nrst === 1'b1) begin
      #1;
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check({18'h0, out_l}, {18'h0, exp_q.pop_front()});
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    failures = 0;
    tests_run = 0;
    seed_v = $urandom(93081);
    repeat (4) @(posedge clk);
    check({31'h0, load_n}, 32'h1);
    check({31'h0, cs_n}, 32'h1);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, 8'h00, 32'h0, rd);
    check(rd, 32'h2);
    check({31'h0, hresp}, 32'h0);
    bus(1'b0, 8'h10, 32'h0, rd);
    check(rd, 32'h0);
    for (int i = 0; i < 7; i++) begin
      w = (i < 4) ? (14'h1fff * i[13:0]) : 14'($urandom);
      xfer(4'h0, w);
    end
    xfer(4'h0, 14'h2000);
    check(32'(signed'(out_l)), 32'hffffe000);
    for (int m = 0; m < 4; m++) begin
      xfer({m == 3, m[1], m[0], 1'b1}, 14'($urandom));
      check({27'h0, bits}, 32'h10);
    end
    xfer(4'h8, 14'($urandom));
    w = 14'($urandom);
    bus(1'b1, 8'h00, 32'h0, rd);
    exp_q.push_back(w);
    bus(1'b1, 8'h04, {18'h0, w}, rd);
    bus(1'b1, 8'h04, {18'h0, ~w}, rd);
    bus(1'b0, 8'h0c, 32'h0, rd);
    check(rd & 32'h2, 32'h2);
    bus(1'b1, 8'h08, 32'h0, rd);
    idle_wait();
    bus(1'b0, 8'h04, 32'h0, rd);
    check(rd, {18'h0, w});
    bus(1'b1, 8'h0c, 32'h2, rd);
    bus(1'b0, 8'h0c, 32'h0, rd);
    check(rd & 32'h2, 32'h0);
    check({31'h0, fault}, 32'h0);
    check(32'(exp_q.size()), 32'h0);
    // frozen enable: pins must hold their idle levels
    ce <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, load_n}, 32'h1);
    check({31'h0, cs_n}, 32'h1);
    ce <= 1'b1;
    @(posedge clk);
    conclude();
  end
endmodule // dacif_top_tb
